/* usb_audio_flags_consts.svh */
`ifndef USB_AUDIO_FLAGS_CONSTS_SVH
`define USB_AUDIO_FLAGS_CONSTS_SVH

// consecutive zero sampling periods before the zero flag rises
`define ZERO_RUN_LEN 11'h0400
// one packet holds 1 ms of audio
`define PACKET_TIME_US 1000
// largest stereo frame count in one packet (48 kHz for 1 ms)
`define PACKET_FRAMES_MAX 7'h30
// bipolar zero for two's complement samples
`define BPZ_SAMPLE 16'h0000

`endif

/* usb_audio_flags_pkg.sv */
package usb_audio_flags_pkg;

  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } frame_type;

  typedef struct packed {
    logic playback_active_n;
    logic bus_suspended_n;
    logic zero_flag;
  } flags_type;

endpackage

/* usb_audio_status_flags.sv */
`timescale 1ns/100ps
`include "usb_audio_flags_consts.svh"

module usb_audio_status_flags
  import usb_audio_flags_pkg::*;
#(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  input wire frame_type in_frame,
  input wire logic in_last,
  input wire logic stream_end,
  input wire logic sof,
  input wire logic sample_tick,
  input wire logic suspend_pin,
  output frame_type out_frame,
  output logic out_strobe,
  output logic in_ready,
  output flags_type flags
);

  typedef enum logic [1:0] {
    IDLE,
    PRIME,
    PLAY,
    DRAIN
  } state_type;

  state_type state_q, state_d;
  frame_type mem [DEPTH];
  logic [AW:0] wr_q, rd_q;
  logic [AW:0] count;
  logic [AW:0] wr_d, rd_d, count_d;
  logic ready_q;
  logic empty, full;
  logic [10:0] zrun_q, zrun_d;
  logic susp_meta_q, susp_sync_q;
  logic play_n_q, susp_n_q, zero_q;
  frame_type out_q;
  logic strobe_q;
  logic ended_q;

  assign count = wr_q - rd_q;
  assign empty = (count == '0);
  assign full = (count == (AW + 1)'(DEPTH));
  assign in_ready = ready_q;

  // silence test shared by the zero counter and its clear path
  function automatic logic is_silent(frame_type f);
    return (f.left == `BPZ_SAMPLE) && (f.right == `BPZ_SAMPLE);
  endfunction

  wire playing = (state_q == PLAY) || (state_q == DRAIN);
  wire take = in_valid && ~full;
  wire pop = playing && sample_tick && ~empty;
  wire frame_zero = is_silent(mem[rd_q[AW-1:0]]);
  assign wr_d = take ? wr_q + 1'b1 : wr_q;
  assign rd_d = pop ? rd_q + 1'b1 : rd_q;
  assign count_d = wr_d - rd_d;

  // a frame lands only when the buffer is not full; a full buffer stalls the host
  always_ff @(posedge clk) begin
    if (take) begin
      mem[wr_q[AW-1:0]] <= in_frame;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (take) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  // ready is a flop that tracks the next fill level, so it equals ~full
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ready_q <= 1'b1;
    end else begin
      ready_q <= (count_d != (AW + 1)'(DEPTH));
    end
  end

  // ended_q remembers stream end until drain takes over
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ended_q <= 1'b0;
    end else if (state_q == IDLE || state_q == DRAIN) begin
      ended_q <= 1'b0;
    end else if (stream_end) begin
      ended_q <= 1'b1;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      IDLE: begin
        if (take) begin
          state_d = PRIME;
        end
      end
      PRIME: begin
        if (sof) begin
          state_d = PLAY;
        end
      end
      PLAY: begin
        if (stream_end || ended_q) begin
          state_d = DRAIN;
        end else if (empty) begin
          state_d = PLAY;
        end
      end
      DRAIN: begin
        if (empty && !take) begin
          state_d = IDLE;
        end
      end
      default: begin
        state_d = IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // zero run counter saturates at the threshold
  always_comb begin
    zrun_d = zrun_q;
    if (!playing) begin
      zrun_d = `ZERO_RUN_LEN;
    end else if (pop && !frame_zero) begin
      zrun_d = '0;
    end else if (pop && zrun_q != `ZERO_RUN_LEN) begin
      zrun_d = zrun_q + 11'h001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      zrun_q <= `ZERO_RUN_LEN;
    end else begin
      zrun_q <= zrun_d;
    end
  end

  // pin from outside the clock domain; two stages before use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      susp_meta_q <= 1'b0;
      susp_sync_q <= 1'b0;
    end else begin
      susp_meta_q <= suspend_pin;
      susp_sync_q <= susp_meta_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      play_n_q <= 1'b1;
      susp_n_q <= 1'b1;
      zero_q <= 1'b1;
    end else begin
      play_n_q <= ~playing;
      susp_n_q <= ~susp_sync_q;
      zero_q <= (zrun_d == `ZERO_RUN_LEN);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= playing && sample_tick;
    end
  end

  // underrun plays silence on both channels rather than repeating a sample
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_q <= frame_type'(0);
    end else begin
      if (pop) begin
        out_q <= mem[rd_q[AW-1:0]];
      end else if (!playing || (sample_tick && empty)) begin
        out_q <= frame_type'({`BPZ_SAMPLE, `BPZ_SAMPLE});
      end
    end
  end

  assign out_frame = out_q;
  assign out_strobe = strobe_q;
  assign flags.playback_active_n = play_n_q;
  assign flags.bus_suspended_n = susp_n_q;
  assign flags.zero_flag = zero_q;

endmodule // usb_audio_status_flags

/* usb_flags_chk_assertions.sv */
`timescale 1ns/100ps
module usb_flags_chk
  import usb_audio_flags_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_ready,
  input wire logic stream_end,
  input wire logic sof,
  input wire logic suspend_pin,
  input wire logic out_strobe,
  input wire frame_type out_frame,
  input wire flags_type flags
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  int z_q;
  // zero run seen at the output, one edge behind the pop
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      z_q <= 0;
    else if (out_strobe)
      z_q <= (out_frame == '0) ? z_q + 1 : 0;
  a_drain_hold: assert property (stream_end && !in_ready |=>
    !flags.playback_active_n[*4]) else $error("early stop");
  a_play_low: assert property (out_strobe |->
    !(flags.playback_active_n && $past(flags.playback_active_n)))
    else $error("sample while stopped");
  a_susp_low: assert property (suspend_pin[*5] |->
    !flags.bus_suspended_n) else $error("no suspend");
  a_zero_run: assert property (z_q > 1024 |-> flags.zero_flag)
    else $error("no zero flag");
  a_idle_bpz: assert property ($rose(flags.playback_active_n) |->
    ##[0:2] (flags.zero_flag && out_frame == '0)) else $error("idle");
  a_sof_start: assert property ($fell(flags.playback_active_n) |->
    $past(sof, 2) || $past(sof, 3)) else $error("start without sof");
  a_zero_clear: assert property (out_strobe && out_frame != '0 |->
    ##[0:1] !flags.zero_flag) else $error("zero flag stuck");
  cover property ($fell(flags.playback_active_n));
  cover property (z_q == 1025);
  cover property (!flags.bus_suspended_n);
endmodule // usb_flags_chk

bind usb_audio_status_flags usb_flags_chk chk (.*);

/* usb_host_model.sv */
`timescale 1ns/100ps
module usb_host_model
  import usb_audio_flags_pkg::*;
(
  input wire logic clk,
  input wire logic en,
  input wire frame_type val,
  input wire logic in_ready,
  output logic in_valid = 0,
  output frame_type in_frame = '0,
  output logic sof = 0,
  output logic sample_tick = 0
);
  logic took = 0;
  logic [5:0] n = '0;
  always @(posedge clk)
    took <= in_valid && in_ready;
  // a frame is held until the edge that takes it
  always @(negedge clk) begin
    n <= n + 6'h01;
    sof <= (n == 6'h00);
    sample_tick <= n[0];
    if (!in_valid || took) begin
      in_valid <= en;
      in_frame <= en ? val : ~in_frame;
    end
  end
endmodule // usb_host_model

/* tb.sv */
`timescale 1ns/100ps
module tb
  import usb_audio_flags_pkg::*;
;
  logic clk = 0, rstn = 0, en = 0, in_last = 0;
  logic stream_end = 0, suspend_pin = 0;
  logic in_valid, in_ready, sof, sample_tick, out_strobe;
  frame_type in_frame, out_frame, val = 32'h1234_5678;
  flags_type flags;
  int failures = 0, n_compared = 0;
  always #25 clk = ~clk;
  usb_host_model host (.*);
  usb_audio_status_flags dut (.*);
  task chk(logic [32:0] got, logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task wt(logic want);
    int i;
    for (i = 0; i < 4000 && flags.playback_active_n !== want; i++)
      @(negedge clk);
    chk(flags.playback_active_n, want);
    if (i == 4000)
      end_of_test();
  endtask
  task t_play;
    en = 1;
    wt(0);
    repeat (3) @(negedge clk);
    chk(out_frame, val);
    chk(flags.zero_flag, 0);
  endtask
  task t_zero;
    val = '0;
    repeat (2600) @(negedge clk);
    chk(flags, 3'h3);
  endtask
  task t_stop;
    en = 0;
    stream_end = 1;
    @(negedge clk);
    stream_end = 0;
    chk(flags.playback_active_n, 0);
    wt(1);
    chk({flags.zero_flag, out_frame}, 33'h1_0000_0000);
  endtask
  task t_susp;
    suspend_pin = 1;
    repeat (5) @(negedge clk);
    chk(flags.bus_suspended_n, 0);
    suspend_pin = 0;
    repeat (5) @(negedge clk);
    chk(flags.bus_suspended_n, 1);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rstn = 1;
    @(negedge clk);
    chk(flags, 3'h7);
    t_play();
    t_zero();
    t_stop();
    t_susp();
    end_of_test();
  end
endmodule // tb
